// File: verilog/asss_sequencer.v
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`include "asss_map.vh"
`timescale 1ns/1ps
`default_nettype none
module asss_sequencer #(
  parameter TICK_CYCLES = `ASSS_TICK_MS * `ASSS_CLK_KHZ
) (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [3:0] term_step_sel,
  output reg [3:0] step_sel_out,
  output reg [15:0] freq_cmd,
  output reg run_fwd,
  output reg run_rev,
  output reg auto_active,
  output reg primary_ramp
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_RUN = 4'b0010;
  localparam ST_HOLD = 4'b0100;
  localparam ST_DONE = 4'b1000;
  reg [6:0] ctrl;
  reg [15:0] freq_tab [0:15];
  reg [15:0] time_tab [0:15];
  reg [1:0] dir_tab [0:15];
  reg [3:0] state;
  reg [3:0] stage;
  reg [15:0] elapsed;
  reg [23:0] tick_cnt;
  reg tick;
  reg [3:0] next_stage;
  reg [3:0] next_state;
  reg any_time;
  reg auto_ok;
  reg stage_end;
  reg cycle_end;
  reg [31:0] wmask;
  reg [31:0] wmerged;
  reg [31:0] rd_mux;
  reg [15:0] fmax;
  integer i;
  integer j;
  wire [2:0] mode = ctrl[`ASSS_CTRL_MODE_LSB +: 3];
  wire run_cmd = ctrl[`ASSS_CTRL_RUN_BIT];
  wire [5:0] word = avs_address[7:2];
  wire [3:0] idx = word[3:0];
  wire resume_mode = (mode == `ASSS_MODE_SINGLE) || (mode == `ASSS_MODE_CONT) ||
                     (mode == `ASSS_MODE_HOLD);
  wire cont_mode = (mode == `ASSS_MODE_CONT) || (mode == `ASSS_MODE_CONT_R);
  wire hold_mode = (mode == `ASSS_MODE_HOLD) || (mode == `ASSS_MODE_HOLD_R);
  wire mode_on = (mode != `ASSS_MODE_OFF) && (mode <= `ASSS_MODE_HOLD_R);
  wire acc = (avs_read || avs_write) && !avs_waitrequest;
  wire [1:0] cur_dir = dir_tab[stage];
  wire [3:0] stage_up = stage + 4'h1;
  wire [1:0] up_dir = dir_tab[stage_up];
  // code 3 counts as stop, so it never drives the motor
  wire cur_moves = (cur_dir == `ASSS_DIR_FWD) || (cur_dir == `ASSS_DIR_REV);
  wire up_moves = (up_dir == `ASSS_DIR_FWD) || (up_dir == `ASSS_DIR_REV);
  always @* begin
    any_time = 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      any_time = any_time | (time_tab[i] != 16'h0000);
    end
  end
  always @* begin
    auto_ok = mode_on && !ctrl[`ASSS_CTRL_WOB_BIT] && !ctrl[`ASSS_CTRL_PID_BIT] && any_time;
  end
  always @* begin
    fmax = ctrl[`ASSS_CTRL_EXT_BIT] ? `ASSS_FREQ_MAX_EXT : `ASSS_FREQ_MAX_STD;
  end
  always @* begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  end
  // unmapped words read zero
  always @* begin
    rd_mux = 32'h00000000;
    case (word[5:4])
      2'h0: begin
        if (word == `ASSS_CTRL_WORD) begin
          rd_mux = {25'h0000000, ctrl};
        end else if (word == `ASSS_STAT_WORD) begin
          rd_mux = {20'h00000, state, stage, 2'h0, auto_ok, run_cmd};
        end
      end
      `ASSS_FREQ_BASE: begin
        rd_mux = {16'h0000, freq_tab[idx]};
      end
      `ASSS_TIME_BASE: begin
        rd_mux = {16'h0000, time_tab[idx]};
      end
      `ASSS_DIR_BASE: begin
        rd_mux = {30'h00000000, dir_tab[idx]};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end
  // partial writes keep the disabled lanes
  always @* begin
    wmerged = (rd_mux & ~wmask) | (avs_writedata & wmask);
  end
  always @* begin
    stage_end = (elapsed >= time_tab[stage]);
    // ascending, end at stop or last
    cycle_end = (stage == `ASSS_LAST_STAGE) || !up_moves;
  end
  always @* begin
    next_state = state;
    next_stage = stage;
    case (state)
      ST_IDLE: begin
        if (run_cmd && auto_ok) begin
          next_state = ST_RUN;
          next_stage = resume_mode ? stage : 4'h0;
        end
      end
      ST_RUN: begin
        if (!auto_ok) begin
          next_state = ST_IDLE;
          next_stage = 4'h0;
        end else if (!run_cmd) begin
          next_state = ST_IDLE;
        end else if (stage_end) begin
          if (!cycle_end) begin
            next_stage = stage + 4'h1;
          end else if (cont_mode) begin
            next_stage = 4'h0;
          end else if (hold_mode) begin
            next_state = ST_HOLD;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_HOLD: begin
        if (!run_cmd || !auto_ok) begin
          next_state = ST_IDLE;
          next_stage = 4'h0;
        end
      end
      ST_DONE: begin
        if (!run_cmd || !auto_ok) begin
          next_state = ST_IDLE;
          next_stage = 4'h0;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_stage = 4'h0;
      end
    endcase
  end
  // one wait cycle per access, so read data is always registered
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      ctrl <= `ASSS_CTRL_RST;
      for (j = 0; j < 16; j = j + 1) begin
        freq_tab[j] <= `ASSS_FREQ_RST;
        time_tab[j] <= `ASSS_TIME_RST;
        dir_tab[j] <= `ASSS_DIR_RST;
      end
    end else begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rd_mux : 32'h00000000;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (acc && avs_write) begin
        if (word == `ASSS_CTRL_WORD) begin
          ctrl <= wmerged[6:0];
        end else if (word[5:4] == `ASSS_FREQ_BASE) begin
          // slot 0 is multi-step speed 0
          freq_tab[idx] <= (wmerged[15:0] > fmax) ? fmax : wmerged[15:0];
        end else if (word[5:4] == `ASSS_TIME_BASE) begin
          time_tab[idx] <= (wmerged[15:0] > `ASSS_TIME_MAX) ? `ASSS_TIME_MAX : wmerged[15:0];
        end else if (word[5:4] == `ASSS_DIR_BASE) begin
          dir_tab[idx] <= wmerged[1:0];
        end
      end
    end
  end
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      stage <= 4'h0;
    end else begin
      state <= next_state;
      stage <= next_stage;
    end
  end
  // divider only runs in RUN, so a stop restarts the tick phase
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= 24'h000000;
      tick <= 1'b0;
    end else begin
      if (state != ST_RUN || tick_cnt == TICK_CYCLES[23:0] - 24'h000001) begin
        tick_cnt <= 24'h000000;
      end else begin
        tick_cnt <= tick_cnt + 24'h000001;
      end
      tick <= (state == ST_RUN) && (tick_cnt == TICK_CYCLES[23:0] - 24'h000001);
    end
  end
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      elapsed <= 16'h0000;
    end else begin
      // elapsed kept across a stop only when resuming the same stage
      if (next_stage != stage || next_state == ST_DONE || next_state == ST_HOLD) begin
        elapsed <= 16'h0000;
      end else if (state == ST_IDLE && next_state == ST_RUN && !resume_mode) begin
        elapsed <= 16'h0000;
      end else if (state == ST_RUN && tick && !stage_end) begin
        elapsed <= elapsed + 16'h0001;
      end
    end
  end
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      freq_cmd <= 16'h0000;
      run_fwd <= 1'b0;
      run_rev <= 1'b0;
      auto_active <= 1'b0;
      primary_ramp <= 1'b0;
      step_sel_out <= 4'h0;
    end else begin
      auto_active <= auto_ok;
      primary_ramp <= auto_ok;
      step_sel_out <= auto_ok ? 4'h0 : term_step_sel;
      if (state == ST_RUN || state == ST_HOLD) begin
        freq_cmd <= cur_moves ? freq_tab[stage] : 16'h0000;
        run_fwd <= (cur_dir == `ASSS_DIR_FWD);
        run_rev <= (cur_dir == `ASSS_DIR_REV);
      end else begin
        freq_cmd <= 16'h0000;
        run_fwd <= 1'b0;
        run_rev <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/asss_map.vh
`ifndef ASSS_MAP_VH
`define ASSS_MAP_VH
`define ASSS_CLK_KHZ 125000
`define ASSS_TICK_MS 100
`define ASSS_CTRL_WORD 6'h00
`define ASSS_STAT_WORD 6'h01
`define ASSS_FREQ_BASE 2'h1
`define ASSS_TIME_BASE 2'h2
`define ASSS_DIR_BASE 2'h3
`define ASSS_CTRL_MODE_LSB 0
`define ASSS_CTRL_EXT_BIT 3
`define ASSS_CTRL_WOB_BIT 4
`define ASSS_CTRL_PID_BIT 5
`define ASSS_CTRL_RUN_BIT 6
`define ASSS_CTRL_RST 7'h00
`define ASSS_FREQ_MAX_STD 16'h9C40
`define ASSS_FREQ_MAX_EXT 16'hE9FC
`define ASSS_TIME_MAX 16'hEA60
`define ASSS_FREQ_RST 16'h0000
`define ASSS_TIME_RST 16'h0000
`define ASSS_DIR_RST 2'h0
`define ASSS_DIR_STOP 2'h0
`define ASSS_DIR_FWD 2'h1
`define ASSS_DIR_REV 2'h2
`define ASSS_MODE_OFF 3'h0
`define ASSS_MODE_SINGLE 3'h1
`define ASSS_MODE_CONT 3'h2
`define ASSS_MODE_HOLD 3'h3
`define ASSS_MODE_SINGLE_R 3'h4
`define ASSS_MODE_CONT_R 3'h5
`define ASSS_MODE_HOLD_R 3'h6
`define ASSS_LAST_STAGE 4'hF
`endif

// File: test/asss_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module asss_chk (
  input wire ref_clk,
  input wire rst,
  input wire avs_waitrequest,
  input wire [3:0] step_sel_out,
  input wire [15:0] freq_cmd,
  input wire run_fwd,
  input wire run_rev,
  input wire auto_active,
  input wire primary_ramp
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  wire mov = run_fwd | run_rev;
  property p_dir; !(run_fwd && run_rev); endproperty
  a_dir: assert property (p_dir) else $error("two directions");
  property p_fz; freq_cmd != 16'h0000 |-> mov; endproperty
  a_fz: assert property (p_fz) else $error("freq while stopped");
  property p_fmax; freq_cmd <= 16'hE9FC; endproperty
  a_fmax: assert property (p_fmax) else $error("freq over range");
  property p_off; !auto_active [*2] |-> !mov && freq_cmd == 16'h0000; endproperty
  a_off: assert property (p_off) else $error("runs while suppressed");
  property p_sel; auto_active [*2] |-> step_sel_out == 4'h0; endproperty
  a_sel: assert property (p_sel) else $error("terminal select leaks");
  property p_ramp; auto_active |-> primary_ramp; endproperty
  a_ramp: assert property (p_ramp) else $error("ramp select off");
  property p_nramp; !auto_active [*2] |-> !primary_ramp; endproperty
  a_nramp: assert property (p_nramp) else $error("ramp select stuck");
  property p_wait; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("wait low too long"); // bus
  c_act: cover property ($rose(auto_active));
  c_turn: cover property (run_fwd ##[1:3] run_rev);
  c_stop: cover property (run_rev ##1 !mov);
endmodule
bind asss_sequencer asss_chk u_chk (.ref_clk, .rst, .avs_waitrequest, .step_sel_out,
  .freq_cmd, .run_fwd, .run_rev, .auto_active, .primary_ramp);
`default_nettype wire

// File: test/asss_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module asss_motor_model (
  input wire ref_clk,
  input wire rst,
  input wire [15:0] freq_cmd,
  input wire run_fwd,
  input wire run_rev,
  output var logic signed [31:0] spd
);
  // signed shaft speed, latched one cycle like a drive input
  always @(posedge ref_clk or posedge rst) begin
    if (rst) spd <= 0;
    else if (run_fwd) spd <= {16'h0000, freq_cmd};
    else if (run_rev) spd <= -$signed({16'h0000, freq_cmd});
    else spd <= 0;
  end
endmodule
`default_nettype wire

// File: test/asss_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module asss_sequencer_tb;
  logic ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
  logic [7:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, rd;
  logic [3:0] term_step_sel = 4'hA;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, run_fwd, run_rev, auto_active, primary_ramp;
  wire [3:0] step_sel_out;
  wire [15:0] freq_cmd;
  wire signed [31:0] spd;
  int bad_count = 0, n_tests = 0, n;
  logic [31:0] sq [4] = '{32'h5DC, 32'hBB8, 32'h1388, 32'hFFFFF830};
  asss_sequencer #(.TICK_CYCLES(10)) dut (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .term_step_sel,
    .step_sel_out, .freq_cmd, .run_fwd, .run_rev, .auto_active, .primary_ramp);
  asss_motor_model mdl (.ref_clk, .rst, .freq_cmd, .run_fwd, .run_rev, .spd);
  initial forever #4 ref_clk = ~ref_clk;
  task give_verdict;
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // master holds the request until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge ref_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    if (avs_waitrequest !== 1'b0) begin
      check(avs_waitrequest, 0);
      give_verdict;
    end
    @(posedge ref_clk);
  endtask
  // waits for a speed change, or for zero, within a bound
  task nxt(input logic [31:0] e, input logic z);
    logic [31:0] c;
    c = spd;
    n = 0;
    while ((z ? spd !== 0 : spd === c) && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    check(spd, e);
    if (spd !== e) give_verdict;
  endtask
  task t_reg;
    bus(1, 8'h40, 32'hFFFF);
    bus(0, 8'h40, 0);
    check(rd, 32'h9C40);
    bus(1, 8'h00, 32'h8);
    bus(1, 8'h40, 32'hFFFF);
    bus(0, 8'h40, 0);
    check(rd, 32'hE9FC);
    bus(1, 8'h80, 32'hFFFF);
    bus(0, 8'h80, 0);
    check(rd, 32'hEA60);
    bus(0, 8'h3C, 0);
    check(rd, 0);
  endtask
  task t_seq(input int m);
    logic [31:0] e;
    e = m % 3 == 1 ? 0 : m % 3 == 2 ? 32'h5DC : 32'hFFFFF830;
    bus(1, 8'h00, 32'h40 | m);
    for (int k = 0; k < 4; k++) begin
      nxt(sq[k], 0);
      if (k == 1) check(32'(n > 10 && n < 25), 1);
    end
    if (m % 3 != 0) nxt(e, 0);
    repeat (60) @(posedge ref_clk);
    if (m % 3 != 2) check(spd, e);
    // mode 0 with run on drops auto and sends the stage back to 0
    bus(1, 8'h00, 32'h40);
    nxt(0, 1);
  endtask
  task t_res(input int m);
    bus(1, 8'h00, 32'h40 | m);
    for (int k = 0; k < 3; k++) nxt(sq[k], 0);
    check(step_sel_out, 0);
    check(primary_ramp, 1);
    bus(1, 8'h00, m);
    nxt(0, 1);
    bus(1, 8'h00, 32'h40 | m);
    nxt(m < 4 ? sq[2] : sq[0], 0);
    bus(1, 8'h00, m);
    nxt(0, 1);
  endtask
  task t_sup;
    for (int b = 4; b < 6; b++) begin
      bus(1, 8'h00, 32'h41 | (1 << b));
      repeat (30) @(posedge ref_clk);
      check(spd, 0);
      check(auto_active, 0);
    end
    bus(1, 8'h00, 0);
    check(step_sel_out, 4'hA);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    t_reg;
    for (int i = 0; i < 4; i++) begin
      bus(1, 8'(8'h40 + 4 * i), i == 3 ? 32'h7D0 : sq[i]);
      bus(1, 8'(8'h80 + 4 * i), i == 2 ? 3 : i ? 1 : 2);
      bus(1, 8'(8'hC0 + 4 * i), i == 3 ? 2 : 1);
    end
    for (int m = 1; m < 7; m++) t_seq(m);
    t_res(1);
    t_res(4);
    t_sup;
    give_verdict;
  end
endmodule
`default_nettype wire
